// *** mfr_pkg.sv ***
package mfr_pkg;
  // read opcodes handled by this block
  localparam logic [7:0] OPC_QOUT  = 8'h6b;
  localparam logic [7:0] OPC_QOUT4 = 8'h6c;
  localparam logic [7:0] OPC_DIO   = 8'hbb;
  localparam logic [7:0] OPC_DIO4  = 8'hbc;
  localparam logic [7:0] OPC_QIO   = 8'heb;
  // field widths in bits
  localparam logic [5:0] OPC_BITS   = 6'h08;
  localparam logic [5:0] ADDR3_BITS = 6'h18;
  localparam logic [5:0] ADDR4_BITS = 6'h20;
  localparam logic [5:0] MODE_BITS  = 6'h08;
  // dummy clock counts
  localparam logic [3:0] QOUT_DUMMY_CLKS    = 4'h8;
  localparam logic [3:0] QIO_SPI_DUMMY_CLKS = 4'h4;
  localparam logic [3:0] NO_DUMMY_CLKS      = 4'h0;
  localparam logic [3:0] QPI_DUMMY_BASE     = 4'h2;
  localparam logic [3:0] QPI_MODE_CLKS      = 4'h2;
  // lane count as a shift amount
  localparam logic [1:0] LG1 = 2'h0;
  localparam logic [1:0] LG2 = 2'h1;
  localparam logic [1:0] LG4 = 2'h2;
  // mode byte field that asks for opcode skipping
  localparam logic [1:0] SKIP_CODE = 2'h2;
  // wrap section masks for length select 0..3
  localparam logic [7:0] WRAP_MASK8  = 8'h07;
  localparam logic [7:0] WRAP_MASK16 = 8'h0f;
  localparam logic [7:0] WRAP_MASK32 = 8'h1f;
  localparam logic [7:0] WRAP_MASK64 = 8'h3f;
  // values after reset
  localparam logic [2:0] WRAP_RESET      = 3'h1;
  localparam logic [1:0] DUMMY_SEL_RESET = 2'h0;

  typedef struct packed {
    logic [1:0] wrap_length_select;
    logic       wrap_disable_bit;
  } mfr_wrap_type;

  typedef struct packed {
    logic         qe;
    logic         four_line_instruction_mode;
    logic         address_size_flag;
    logic [7:0]   ext;
    mfr_wrap_type wrap;
    logic [1:0]   dsel;
  } mfr_cfg_type;

  typedef struct packed {
    logic [7:0] opcode;
    logic       known;
    logic       ok;
    logic [1:0] alg;
    logic [5:0] abits;
    logic       mode;
    logic [3:0] dclks;
    logic [1:0] dlg;
    logic       wrap;
  } mfr_prof_type;

  typedef enum logic [2:0] {ST_IDLE, ST_CMD, ST_ADDR, ST_MODE, ST_DUMMY, ST_DATA, ST_IGNORE}
    mfr_state_type;
endpackage : mfr_pkg

// *** mfr_flash_read.sv ***
`timescale 1ns/1ps
`default_nettype none
module mfr_flash_read (
  input  wire logic                  clk_i,
  input  wire logic                  arst_n_i,
  input  wire logic                  quad_lines_enable_bit_i,
  input  wire logic                  four_line_instruction_mode_i,
  input  wire logic                  address_size_flag_i,
  input  wire logic [7:0]            ext_addr_i,
  input  wire mfr_pkg::mfr_wrap_type wrap_setting_bits_i,
  input  wire logic                  wrap_load_i,
  input  wire logic [1:0]            read_param_i,
  input  wire logic                  read_param_load_i,
  input  wire logic                  soft_reset_i,
  output logic                       skip_active_o,
  output logic                       read_active_o,
  output logic                       refused_o,
  input  wire logic                  sck_i,
  input  wire logic                  cs_n_i,
  input  wire logic [3:0]            io_i,
  output logic [3:0]                 io_o,
  output logic [3:0]                 io_oe_o,
  output logic [31:0]                mem_addr_o,
  input  wire logic [7:0]            mem_data_i
);
  import mfr_pkg::*;

  mfr_wrap_type  wrap_q;
  logic [1:0]    dsel_q;
  mfr_cfg_type   cfg_q;
  mfr_cfg_type   cfg_s1_q;
  mfr_cfg_type   cfg_s2_q;
  mfr_prof_type  prof_q;
  mfr_prof_type  dec;
  mfr_state_type st_q;
  mfr_state_type st_d;
  mfr_state_type st_eff;
  logic          frame_rst_n;
  logic          skip_q;
  logic [5:0]    cnt_q;
  logic [5:0]    cnt_d;
  logic [31:0]   sh_q;
  logic [31:0]   sh_d;
  logic [31:0]   addr_q;
  logic [31:0]   addr_d;
  logic [2:0]    bpos_q;
  logic [2:0]    bpos_d;
  logic [3:0]    bsum;
  logic          byte_done;
  logic [1:0]    cmd_lg;
  logic          cmd_last;
  logic          load_prof;
  logic          mode_done;
  logic          refuse;
  logic          ref_tgl_q;
  logic [1:0]    skip_s_q;
  logic [1:0]    act_s_q;
  logic [2:0]    tgl_s_q;
  logic          refused_q;
  logic [3:0]    io_q;
  logic [3:0]    oe_q;
  logic [7:0]    shifted;
  logic [31:0]   wrap_next;
  logic [31:0]   cmd_sh;

  // serial input shift by lane count
  function automatic logic [31:0] shift_in(input logic [31:0] s, input logic [3:0] io,
                                           input logic [1:0] lg);
    case (lg)
      LG2:     shift_in = {s[29:0], io[1:0]};
      LG4:     shift_in = {s[27:0], io};
      default: shift_in = {s[30:0], io[0]};
    endcase
  endfunction : shift_in

  // opcode decode into a transfer profile
  function automatic mfr_prof_type decode(input logic [7:0] op, input mfr_cfg_type c);
    mfr_prof_type p;
    p        = '0;
    p.opcode = op;
    p.abits  = c.address_size_flag ? ADDR4_BITS : ADDR3_BITS;
    p.dclks  = NO_DUMMY_CLKS;
    case (op)
      OPC_QOUT, OPC_QOUT4: begin
        p.known = 1'b1;
        p.ok    = c.qe & ~c.four_line_instruction_mode;
        p.alg   = LG1;
        p.dclks = QOUT_DUMMY_CLKS;
        p.dlg   = LG4;
        if (op == OPC_QOUT4) begin
          p.abits = ADDR4_BITS;
        end
      end
      OPC_DIO, OPC_DIO4: begin
        p.known = 1'b1;
        p.ok    = ~c.four_line_instruction_mode;
        p.alg   = LG2;
        p.mode  = 1'b1;
        p.dlg   = LG2;
        if (op == OPC_DIO4) begin
          p.abits = ADDR4_BITS;
        end
      end
      OPC_QIO: begin
        p.known = 1'b1;
        p.ok    = c.qe;
        p.alg   = LG4;
        p.mode  = 1'b1;
        p.dlg   = LG4;
        // mode byte takes two of the four-line dummies
        p.dclks = c.four_line_instruction_mode ? QPI_DUMMY_BASE + 4'({c.dsel, 1'b0}) - QPI_MODE_CLKS
                        : QIO_SPI_DUMMY_CLKS;
        p.wrap  = ~c.four_line_instruction_mode & ~c.wrap.wrap_disable_bit;
      end
      default: begin
        p.known = 1'b0;
      end
    endcase
    return p;
  endfunction : decode

  // wrap setting and dummy select held in the system domain
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wrap_q <= WRAP_RESET;
    end else if (wrap_load_i) begin
      wrap_q <= wrap_setting_bits_i;
    end
  end

  // dummy select returns to two clocks on reset instruction
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dsel_q <= DUMMY_SEL_RESET;
    end else if (soft_reset_i) begin
      dsel_q <= DUMMY_SEL_RESET;
    end else if (read_param_load_i) begin
      dsel_q <= read_param_i;
    end
  end

  // configuration snapshot launched toward the link
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cfg_q <= '0;
    end else begin
      cfg_q <= {quad_lines_enable_bit_i, four_line_instruction_mode_i, address_size_flag_i,
                ext_addr_i, wrap_q, dsel_q};
    end
  end

  // two-stage crossing of the quasi-static configuration
  always_ff @(posedge sck_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cfg_s1_q <= '0;
      cfg_s2_q <= '0;
    end else begin
      cfg_s1_q <= cfg_q;
      cfg_s2_q <= cfg_s1_q;
    end
  end

  // a raised chip select ends the frame at once
  assign frame_rst_n = arst_n_i & ~cs_n_i;

  // frame starts with the address when skipping
  assign st_eff = (st_q == ST_IDLE) ? (skip_q ? ST_ADDR : ST_CMD) : st_q;
  assign cmd_lg = cfg_s2_q.four_line_instruction_mode ? LG4 : LG1;

  // next address, kept inside the wrap section
  always_comb begin
    logic [7:0] m;
    m = WRAP_MASK8;
    case (prof_q.wrap ? wrap_q_sel(cfg_s2_q) : 2'h0)
      2'h1:    m = WRAP_MASK16;
      2'h2:    m = WRAP_MASK32;
      2'h3:    m = WRAP_MASK64;
      default: m = WRAP_MASK8;
    endcase
    if (prof_q.wrap) begin
      wrap_next = {addr_q[31:8], (addr_q[7:0] & ~m) | ((addr_q[7:0] + 8'h01) & m)};
    end else begin
      wrap_next = addr_q + 32'h1;
    end
  end

  function automatic logic [1:0] wrap_q_sel(input mfr_cfg_type c);
    return c.wrap.wrap_length_select;
  endfunction : wrap_q_sel

  // byte position advance during data out
  assign bsum      = {1'b0, bpos_q} + (4'h1 << prof_q.dlg);
  assign byte_done = bsum[3];

  // frame sequencing on the rising edge
  always_comb begin
    st_d      = st_eff;
    cnt_d     = cnt_q + 6'h01;
    sh_d      = sh_q;
    addr_d    = addr_q;
    bpos_d    = bpos_q;
    cmd_last  = 1'b0;
    load_prof = 1'b0;
    mode_done = 1'b0;
    refuse    = 1'b0;
    // opcode as it stands once this edge's bits are in
    cmd_sh    = shift_in(sh_q, io_i, cmd_lg);
    dec       = decode(cmd_sh[7:0], cfg_s2_q);
    case (st_eff)
      ST_CMD: begin
        sh_d = cmd_sh;
        if (cnt_q + 6'h01 == (OPC_BITS >> cmd_lg)) begin
          cmd_last  = 1'b1;
          cnt_d     = 6'h00;
          load_prof = dec.ok;
          refuse    = dec.known & ~dec.ok;
          st_d      = dec.ok ? ST_ADDR : ST_IGNORE;
        end
      end
      ST_ADDR: begin
        sh_d = shift_in(sh_q, io_i, prof_q.alg);
        if (cnt_q + 6'h01 == (prof_q.abits >> prof_q.alg)) begin
          cnt_d  = 6'h00;
          addr_d = (prof_q.abits == ADDR4_BITS) ? sh_d : {cfg_s2_q.ext, sh_d[23:0]};
          if (prof_q.mode) begin
            st_d = ST_MODE;
          end else begin
            st_d = (prof_q.dclks == NO_DUMMY_CLKS) ? ST_DATA : ST_DUMMY;
          end
        end
      end
      ST_MODE: begin
        sh_d = shift_in(sh_q, io_i, prof_q.alg);
        if (cnt_q + 6'h01 == (MODE_BITS >> prof_q.alg)) begin
          cnt_d     = 6'h00;
          mode_done = 1'b1;
          st_d      = (prof_q.dclks == NO_DUMMY_CLKS) ? ST_DATA : ST_DUMMY;
        end
      end
      ST_DUMMY: begin
        if (cnt_q + 6'h01 == {2'h0, prof_q.dclks}) begin
          cnt_d = 6'h00;
          st_d  = ST_DATA;
        end
      end
      ST_DATA: begin
        cnt_d  = 6'h00;
        bpos_d = bsum[2:0];
        if (byte_done) begin
          addr_d = wrap_next;
        end
      end
      ST_IGNORE: begin
        cnt_d = 6'h00;
      end
      default: begin
        st_d  = ST_IGNORE;
        cnt_d = 6'h00;
      end
    endcase
  end

  // frame state, cleared whenever chip select is high
  always_ff @(posedge sck_i or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      st_q   <= ST_IDLE;
      cnt_q  <= 6'h00;
      sh_q   <= 32'h0;
      addr_q <= 32'h0;
      bpos_q <= 3'h0;
    end else begin
      st_q   <= st_d;
      cnt_q  <= cnt_d;
      sh_q   <= sh_d;
      addr_q <= addr_d;
      bpos_q <= bpos_d;
    end
  end

  // profile of the last accepted read survives the frame
  always_ff @(posedge sck_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      prof_q <= '0;
    end else if (load_prof) begin
      prof_q <= dec;
    end
  end

  // opcode skip state, kept across chip select cycles
  always_ff @(posedge sck_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      skip_q <= 1'b0;
    end else if (mode_done) begin
      skip_q <= (sh_d[5:4] == SKIP_CODE);
    end
  end

  // refused reads reported as a toggle
  always_ff @(posedge sck_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ref_tgl_q <= 1'b0;
    end else if (refuse) begin
      ref_tgl_q <= ~ref_tgl_q;
    end
  end

  // data lanes selected from the addressed byte
  assign shifted = mem_data_i << bpos_q;

  // data and enables change on the falling edge
  always_ff @(negedge sck_i or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      io_q <= 4'h0;
      oe_q <= 4'h0;
    end else if (st_q == ST_DATA) begin
      io_q <= (prof_q.dlg == LG4) ? shifted[7:4] : {2'h0, shifted[7:6]};
      oe_q <= (prof_q.dlg == LG4) ? 4'hf : 4'h3;
    end else begin
      io_q <= 4'h0;
      oe_q <= 4'h0;
    end
  end

  assign io_o       = io_q;
  assign io_oe_o    = oe_q;
  assign mem_addr_o = addr_q;

  // link state brought into the system domain
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      skip_s_q  <= 2'h0;
      act_s_q   <= 2'h0;
      tgl_s_q   <= 3'h0;
      refused_q <= 1'b0;
    end else begin
      skip_s_q  <= {skip_s_q[0], skip_q};
      act_s_q   <= {act_s_q[0], st_q == ST_DATA};
      tgl_s_q   <= {tgl_s_q[1:0], ref_tgl_q};
      refused_q <= tgl_s_q[2] ^ tgl_s_q[1];
    end
  end

  assign skip_active_o = skip_s_q[1];
  assign read_active_o = act_s_q[1];
  assign refused_o     = refused_q;

  // checks on the link side
  sequence s_dummy8;
    (st_q == ST_DUMMY) [*8] ##1 (st_q == ST_DATA);
  endsequence

  sequence s_dummy4;
    (st_q == ST_DUMMY) [*4] ##1 (st_q == ST_DATA);
  endsequence

  property p_quad_lanes;
    @(posedge sck_i) disable iff (!frame_rst_n)
      (st_q == ST_DATA && prof_q.dlg == LG4) |-> io_oe_o == 4'hf;
  endproperty
  a_quad_lanes: assert property (p_quad_lanes) else $error("quad data not on four lanes");

  property p_qe_refuse;
    @(posedge sck_i) disable iff (!frame_rst_n)
      (cmd_last && !cfg_s2_q.qe && dec.opcode == OPC_QOUT) |=> st_q == ST_IGNORE;
  endproperty
  a_qe_refuse: assert property (p_qe_refuse) else $error("quad output taken without enable");

  property p_qout_dummy;
    @(posedge sck_i) disable iff (!frame_rst_n)
      ($rose(st_q == ST_DUMMY) && prof_q.dlg == LG4 && !prof_q.mode) |-> s_dummy8;
  endproperty
  a_qout_dummy: assert property (p_qout_dummy) else $error("quad output dummy not eight");

  property p_qout4_addr;
    @(posedge sck_i) disable iff (!frame_rst_n)
      ($fell(st_q == ST_ADDR) && prof_q.opcode == OPC_QOUT4) |-> $past(cnt_q) == 6'h1f;
  endproperty
  a_qout4_addr: assert property (p_qout4_addr) else $error("explicit 4-byte not 32 bits");

  property p_dual_lanes;
    @(posedge sck_i) disable iff (!frame_rst_n)
      (st_q == ST_DATA && prof_q.dlg == LG2) |-> io_oe_o == 4'h3;
  endproperty
  a_dual_lanes: assert property (p_dual_lanes) else $error("dual data not on two lanes");

  property p_skip_start;
    @(posedge sck_i) disable iff (!frame_rst_n)
      (st_q == ST_IDLE && skip_q) |=> (st_q == ST_ADDR);
  endproperty
  a_skip_start: assert property (p_skip_start) else $error("skip frame did not start at address");

  property p_skip_clear;
    @(posedge sck_i) disable iff (!arst_n_i)
      (mode_done && sh_d[5:4] != SKIP_CODE) |=> !skip_q;
  endproperty
  a_skip_clear: assert property (p_skip_clear) else $error("skip state not cleared");

  property p_qio_dummy;
    @(posedge sck_i) disable iff (!frame_rst_n)
      ($rose(st_q == ST_DUMMY) && prof_q.opcode == OPC_QIO && !cfg_s2_q.four_line_instruction_mode) |-> s_dummy4;
  endproperty
  a_qio_dummy: assert property (p_qio_dummy) else $error("quad io dummy not four");

  property p_wrap_page;
    @(posedge sck_i) disable iff (!frame_rst_n)
      (st_q == ST_DATA && byte_done && prof_q.wrap) |=> addr_q[31:8] == $past(addr_q[31:8]);
  endproperty
  a_wrap_page: assert property (p_wrap_page) else $error("wrap left its page");

  property p_qpi_nowrap;
    @(posedge sck_i) disable iff (!arst_n_i)
      (load_prof && cfg_s2_q.four_line_instruction_mode) |=> !prof_q.wrap;
  endproperty
  a_qpi_nowrap: assert property (p_qpi_nowrap) else $error("wrap on in four-line mode");

  property p_qpi_default;
    @(posedge sck_i) disable iff (!frame_rst_n)
      ($fell(st_q == ST_MODE) && cfg_s2_q.four_line_instruction_mode && cfg_s2_q.dsel == DUMMY_SEL_RESET)
        |-> st_q == ST_DATA;
  endproperty
  a_qpi_default: assert property (p_qpi_default) else $error("data not right after mode");

  property p_dual_addr4;
    @(posedge sck_i) disable iff (!frame_rst_n)
      ($fell(st_q == ST_ADDR) && prof_q.opcode == OPC_DIO && prof_q.abits == ADDR4_BITS)
        |-> $past(cnt_q) == 6'h0f;
  endproperty
  a_dual_addr4: assert property (p_dual_addr4) else $error("dual 4-byte address length");
endmodule : mfr_flash_read
`default_nettype wire

// *** mfr_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// behavioural host controller: drives chip select, serial clock and io lines
module mfr_host_model (
  output logic            sck_o,
  output logic            cs_n_o,
  input  wire logic [3:0] dev_io_i,
  input  wire logic [3:0] dev_oe_i,
  output logic [3:0]      io_o
);
  logic [3:0] drv;
  logic       drv_en;
  logic [3:0] rel;

  // released lines show a pattern that flips each clock, never the last value
  assign io_o = (dev_oe_i & dev_io_i) | (~dev_oe_i & (drv_en ? drv : rel));

  // idle levels
  initial begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    drv = 4'h0;
    drv_en = 1'b0;
    rel = 4'h5;
  end

  // one 6 ns link clock; sample on rise, optionally let go before the fall
  task automatic tick(input logic drop, output logic [3:0] s);
    #3 sck_o = 1'b1;
    s = io_o;
    // let go a little after the rise so the last bits are sampled cleanly
    #1;
    if (drop) drv_en = 1'b0;
    #2 sck_o = 1'b0;
    rel = ~rel;
  endtask : tick

  // config sync pulses with chip select high
  task automatic sync();
    logic [3:0] s;
    repeat (4) tick(1'b0, s);
  endtask : sync

  task automatic start();
    cs_n_o = 1'b0;
  endtask : start

  task automatic stop();
    drv_en = 1'b0;
    #3 cs_n_o = 1'b1;
    #120;
  endtask : stop

  // msb first, lanes bits per clock on io[lanes-1:0]
  task automatic shift(input logic [31:0] v, input int n, input int lanes, input logic last);
    logic [3:0] s;
    drv_en = 1'b1;
    for (int i = n - lanes; i >= 0; i -= lanes) begin
      drv = 4'(v >> i) & ((4'h1 << lanes) - 4'h1);
      tick(last && (i == 0), s);
    end
  endtask : shift

  // dummy clocks with the lines released
  task automatic idle(input int n);
    logic [3:0] s;
    drv_en = 1'b0;
    repeat (n) tick(1'b0, s);
  endtask : idle

  task automatic grab(input int lanes, output logic [7:0] b);
    logic [3:0] s;
    b = 8'h00;
    repeat (8 / lanes) begin
      tick(1'b0, s);
      b = (b << lanes) | 8'(s & ((4'h1 << lanes) - 4'h1));
    end
  endtask : grab
endmodule : mfr_host_model
`default_nettype wire

// *** multi_io_flash_read_commands_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module multi_io_flash_read_commands_test;
  import mfr_pkg::*;
  // opc, cfg {0,qe,qpi,ads}, dsel, abits, addr lanes, data lanes, dummies, {0,0,mode,ok}
  typedef struct packed {
    logic [7:0] opc;
    logic [3:0] cfg;
    logic [3:0] dsel;
    logic [7:0] abits;
    logic [3:0] alg;
    logic [3:0] dlg;
    logic [3:0] dummy;
    logic [3:0] fl;
  } mfr_row_type;
  localparam mfr_row_type ROWS [15] = '{
    40'h6b_4_0_18_1_4_8_1, 40'h6b_0_0_18_1_4_8_0, 40'h6b_5_0_20_1_4_8_1,
    40'h6c_4_0_20_1_4_8_1, 40'h6c_6_0_20_1_4_8_0, 40'hbb_0_0_18_2_2_0_3,
    40'hbb_1_0_20_2_2_0_3, 40'hbc_0_0_20_2_2_0_3, 40'hbc_6_0_20_2_2_0_2,
    40'heb_4_0_18_4_4_4_3, 40'heb_0_0_18_4_4_4_2, 40'heb_6_0_18_4_4_0_3,
    40'heb_6_1_18_4_4_2_3, 40'heb_6_2_18_4_4_4_3, 40'heb_7_3_20_4_4_6_3};
  localparam logic [7:0] EXT = 8'hc3;
  logic         clk_i, arst_n_i, qe, four_line_instruction_mode, address_size_flag, rp_ld, wrap_ld, soft_rst;
  logic [1:0]   rp;
  mfr_wrap_type wrap_set;
  logic         skip_act, rd_act, refused, sck, cs_n;
  logic [3:0]   io_dut, io_bus, io_oe;
  logic [31:0]  mem_addr;
  logic [7:0]   mem_data, wmask [4];
  mfr_row_type  r;
  int           n_errors, compares, n_ref;

  // byte stored at an address mixes low and top address bytes
  assign mem_data = mem_addr[7:0] ^ mem_addr[31:24];

  mfr_flash_read dut (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .quad_lines_enable_bit_i(qe),
    .four_line_instruction_mode_i(four_line_instruction_mode), .address_size_flag_i(address_size_flag), .ext_addr_i(EXT),
    .wrap_setting_bits_i(wrap_set), .wrap_load_i(wrap_ld), .read_param_i(rp),
    .read_param_load_i(rp_ld), .soft_reset_i(soft_rst), .skip_active_o(skip_act),
    .read_active_o(rd_act), .refused_o(refused), .sck_i(sck), .cs_n_i(cs_n),
    .io_i(io_bus), .io_o(io_dut), .io_oe_o(io_oe), .mem_addr_o(mem_addr),
    .mem_data_i(mem_data));

  mfr_host_model host (.sck_o(sck), .cs_n_o(cs_n), .dev_io_i(io_dut), .dev_oe_i(io_oe),
    .io_o(io_bus));

  // 10 MHz system clock
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  // count refusal pulses
  always @(posedge clk_i) begin
    if (refused === 1'b1) n_ref <= n_ref + 1;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic end_sim();
    $display("checks %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_sim

  // config levels and load pulses, then let them reach the link side
  task automatic cfg(input mfr_row_type c, input logic [2:0] w);
    @(posedge clk_i);
    qe <= c.cfg[2];
    four_line_instruction_mode <= c.cfg[1];
    address_size_flag <= c.cfg[0];
    rp <= c.dsel[1:0];
    rp_ld <= 1'b1;
    wrap_set <= w;
    wrap_ld <= 1'b1;
    @(posedge clk_i);
    rp_ld <= 1'b0;
    wrap_ld <= 1'b0;
    repeat (5) @(posedge clk_i);
    host.sync();
  endtask : cfg

  // one read frame: opcode unless skipped, address, mode, dummies, three bytes
  task automatic rd(input logic skip, input logic [7:0] mode, input logic [7:0] wm);
    logic [31:0] a;
    logic [7:0]  b;
    int          rc;
    rc = n_ref;
    a = (r.abits == 8'h20) ? 32'h1234_567e : {EXT, 24'h34_567e};
    if (wm != 8'h00) a[7:0] = 8'h40 | (wm - 8'h01);
    host.start();
    if (!skip) host.shift(32'(r.opc), 8, four_line_instruction_mode ? 4 : 1, 1'b0);
    host.shift(a, int'(r.abits), int'(r.alg), 1'b0);
    if (r.fl[1]) host.shift(32'(mode), 8, int'(r.alg), r.dummy == 4'h0);
    host.idle(int'(r.dummy));
    for (int k = 0; k < 3; k++) begin
      host.grab(int'(r.dlg), b);
      if (r.fl[0]) check("data", 32'(b), 32'(a[7:0] ^ a[31:24]));
      a = (wm != 8'h00) ? ((a & ~32'(wm)) | ((a + 32'h1) & 32'(wm))) : a + 32'h1;
    end
    // clock paused mid-frame so the data phase reaches the system side
    repeat (2) @(posedge clk_i);
    #1;
    check("active", 32'(rd_act), 32'(r.fl[0]));
    check("oe", 32'(io_oe), r.fl[0] ? ((r.dlg == 4'h4) ? 32'hf : 32'h3) : 32'h0);
    host.stop();
    repeat (8) @(posedge clk_i);
    check("refused", 32'(n_ref - rc), r.fl[0] ? 32'h0 : 32'h1);
    check("active end", 32'(rd_act), 32'h0);
  endtask : rd

  // watchdog
  initial begin
    #500us;
    n_errors++;
    end_sim();
  end

  initial begin
    {arst_n_i, qe, four_line_instruction_mode, address_size_flag, rp_ld, wrap_ld, soft_rst, rp} = '0;
    wrap_set = WRAP_RESET;
    wmask = '{WRAP_MASK8, WRAP_MASK16, WRAP_MASK32, WRAP_MASK64};
    n_errors = 0;
    compares = 0;
    n_ref = 0;
    host.sync();
    repeat (3) @(posedge clk_i);
    check("reset outs", 32'({skip_act, rd_act, refused, io_oe}), 32'h0);
    arst_n_i <= 1'b1;
    $display("reset test done");
    // table of ordinary reads
    foreach (ROWS[i]) begin
      r = ROWS[i];
      cfg(r, WRAP_RESET);
      rd(1'b0, 8'h0f, 8'h00);
      $display("row %0d done", i);
    end
    // opcode skipping for dual, quad and four-line quad reads
    foreach (ROWS[i]) begin
      if (i == 5 || i == 9 || i == 11) begin
        r = ROWS[i];
        cfg(r, WRAP_RESET);
        rd(1'b0, 8'h2a, 8'h00);
        repeat (4) @(posedge clk_i);
        #1;
        check("skip set", 32'(skip_act), 32'h1);
        rd(1'b1, 8'h25, 8'h00);
        rd(1'b1, 8'hff, 8'h00);
        repeat (4) @(posedge clk_i);
        #1;
        check("skip clear", 32'(skip_act), 32'h0);
        rd(1'b0, 8'h0f, 8'h00);
        $display("skip test %0d done", i);
      end
    end
    // wrap inside each section length, then none in four-line mode
    r = ROWS[9];
    for (int l = 0; l < 4; l++) begin
      cfg(r, {2'(l), 1'b0});
      rd(1'b0, 8'h0f, wmask[l]);
    end
    r = ROWS[11];
    cfg(r, 3'h0);
    rd(1'b0, 8'h0f, 8'h00);
    $display("wrap test done");
    // soft reset returns the four-line dummy count to two
    r.dsel = 4'h3;
    cfg(r, WRAP_RESET);
    @(posedge clk_i);
    soft_rst <= 1'b1;
    @(posedge clk_i);
    soft_rst <= 1'b0;
    repeat (5) @(posedge clk_i);
    host.sync();
    r = ROWS[11];
    rd(1'b0, 8'h0f, 8'h00);
    // hard reset in mid-run clears the skip state
    rd(1'b0, 8'h20, 8'h00);
    repeat (4) @(posedge clk_i);
    #1;
    check("skip before reset", 32'(skip_act), 32'h1);
    @(posedge clk_i);
    arst_n_i <= 1'b0;
    host.sync();
    @(posedge clk_i);
    arst_n_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    #1;
    check("skip after reset", 32'(skip_act), 32'h0);
    $display("reset default test done");
    end_sim();
  end
endmodule : multi_io_flash_read_commands_test
`default_nettype wire
